// ---- src/pts_top.sv ----
// pwm timebase selection register with apb access and per-module timebase muxes
// Behaviour
// - bits 7:6 select the timebase of pwm module four: 10 timer 6, 01 timer 4, 00 timer 2, 11 reserved.
// - bits 5:4 select the timebase of pwm module three with the same encoding.
// - bits 3:2 select the timebase of pwm module two, 10 meaning timer 6.
// - the selection governs a module only in pwm mode, and 00 (timer 2) is the default.
`timescale 1ns/1ps
`default_nettype none
module pts_top
   import pts_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // timer period-match pulses: bit 0 timer 2, bit 1 timer 4, bit 2 timer 6
   input  wire logic [2:0]  timer_tick_in,
   // per-module selected timebase
   output logic [3:0]       pwm_tick_out,
   output logic [3:0]       pwm_active_out,
   output logic [7:0]       sel_out
);
   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   typedef struct packed
   {
      pts_regs_type regs;
      logic [31:0]  rdata;
      logic         err;
   } pts_state_type;

   pts_state_type state;
   pts_state_type next_state;
   logic          access;
   logic          setup;
   logic          hit_sel;
   logic          hit_mode;

   assign access   = psel_in && penable_in;
   assign setup    = psel_in && !penable_in;
   assign hit_sel  = (paddr_in == PTS_SEL0_OFFSET);
   assign hit_mode = (paddr_in == PTS_MODE_OFFSET);

   // setup phase latches read data and the error answer, so that both leave
   // flip-flops in the access phase; the access phase commits writes
   always_comb
   begin
      next_state = state;
      if (setup)
      begin
         next_state.err   = !(hit_sel || hit_mode);
         next_state.rdata = 32'h0000_0000;
         if (!pwrite_in && hit_sel)
            next_state.rdata = {24'h00_0000, state.regs.sel};
         if (!pwrite_in && hit_mode)
            next_state.rdata = {28'h000_0000, state.regs.pwm_mode};
      end
      if (access)
      begin
         if (pwrite_in && hit_sel && pstrb_in[0])
            next_state.regs.sel = pwdata_in[7:0];
         if (pwrite_in && hit_mode && pstrb_in[0])
            next_state.regs.pwm_mode = pwdata_in[3:0];
      end
   end

   // register the state; reset selects timer 2 everywhere
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         state.regs.sel      <= PTS_SEL0_RESET;
         state.regs.pwm_mode <= PTS_MODE_RESET;
         state.rdata         <= 32'h0000_0000;
         state.err           <= 1'b0;
      end
      else
         state <= next_state;
   end

   // zero wait states; read data and error come from the setup-phase flops
   assign pready_out  = 1'b1;
   assign prdata_out  = state.rdata;
   assign pslverr_out = access && state.err;
   assign sel_out     = state.regs.sel;

   // -----------------------------------------------------------
   // timebase muxes, one per pwm module
   // -----------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PTS_NUM_MOD; g++)
      begin : g_mux
         pts_tb_mux u_mux
         (
            .sel_in      (state.regs.sel[2*g +: 2]),
            .pwm_mode_in (state.regs.pwm_mode[g]),
            .tick_in     (timer_tick_in),
            .tick_out    (pwm_tick_out[g]),
            .active_out  (pwm_active_out[g])
         );
      end
   endgenerate

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   a_mod4_timer6: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (state.regs.sel[7:6] == 2'b10 && state.regs.pwm_mode[3]) |-> pwm_tick_out[3] == timer_tick_in[2])
      else $error("module four not on timer 6");
   a_mod3_timer4: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (state.regs.sel[5:4] == 2'b01 && state.regs.pwm_mode[2]) |-> pwm_tick_out[2] == timer_tick_in[1])
      else $error("module three not on timer 4");
   a_mod2_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (access && pwrite_in && hit_sel && pstrb_in[0]) |=> state.regs.sel[3:2] == $past(pwdata_in[3:2]))
      else $error("module two field not written");
   a_nopwm_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !state.regs.pwm_mode[0] |-> !pwm_tick_out[0] && !pwm_active_out[0])
      else $error("timebase routed outside pwm mode");
   a_reset_clear: assert property (@(posedge clk_in)
      !rstn_in |=> sel_out == 8'h00)
      else $error("selection not cleared by reset");
   a_sel_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !(access && pwrite_in && hit_sel) |=> $stable(sel_out))
      else $error("selection changed without write");
   a_read_back: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (access && !pwrite_in && hit_sel) |-> prdata_out == {24'h00_0000, sel_out})
      else $error("read data differs from selection");
   a_mod1_timer2: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[1:0] == 2'b00 && state.regs.pwm_mode[0]) |-> pwm_tick_out[0] == timer_tick_in[0])
      else $error("module one not on timer 2");

   // -----------------------------------------------------------
   // timebase routing, the legal codes of each module not covered by the assertions above
   // -----------------------------------------------------------
   // module one, codes 01 and 10
   a_mod1_timer4: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[1:0] == 2'b01 && state.regs.pwm_mode[0]) |-> pwm_tick_out[0] == timer_tick_in[1])
      else $error("module one not on timer 4");
   a_mod1_timer6: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[1:0] == 2'b10 && state.regs.pwm_mode[0]) |-> pwm_tick_out[0] == timer_tick_in[2])
      else $error("module one not on timer 6");
   // module two, codes 00, 01 and 10
   a_mod2_timer2: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[3:2] == 2'b00 && state.regs.pwm_mode[1]) |-> pwm_tick_out[1] == timer_tick_in[0])
      else $error("module two not on timer 2");
   a_mod2_timer4: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[3:2] == 2'b01 && state.regs.pwm_mode[1]) |-> pwm_tick_out[1] == timer_tick_in[1])
      else $error("module two not on timer 4");
   a_mod2_timer6: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[3:2] == 2'b10 && state.regs.pwm_mode[1]) |-> pwm_tick_out[1] == timer_tick_in[2])
      else $error("module two not on timer 6");
   // module three, codes 00 and 10
   a_mod3_timer2: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[5:4] == 2'b00 && state.regs.pwm_mode[2]) |-> pwm_tick_out[2] == timer_tick_in[0])
      else $error("module three not on timer 2");
   a_mod3_timer6: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[5:4] == 2'b10 && state.regs.pwm_mode[2]) |-> pwm_tick_out[2] == timer_tick_in[2])
      else $error("module three not on timer 6");
   // module four, codes 00 and 01
   a_mod4_timer2: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[7:6] == 2'b00 && state.regs.pwm_mode[3]) |-> pwm_tick_out[3] == timer_tick_in[0])
      else $error("module four not on timer 2");
   a_mod4_timer4: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (sel_out[7:6] == 2'b01 && state.regs.pwm_mode[3]) |-> pwm_tick_out[3] == timer_tick_in[1])
      else $error("module four not on timer 4");

   // -----------------------------------------------------------
   // pwm mode gating
   // -----------------------------------------------------------
   // a module outside pwm mode neither ticks nor reports itself active
   a_gate_ticks: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (pwm_tick_out & ~state.regs.pwm_mode) == 4'h0)
      else $error("tick routed to a module outside pwm mode");
   a_gate_active: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (pwm_active_out & ~state.regs.pwm_mode) == 4'h0)
      else $error("module active outside pwm mode");
   // in pwm mode with a legal code the module reports itself active
   a_active_mod1: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (state.regs.pwm_mode[0] && sel_out[1:0] != 2'b11) |-> pwm_active_out[0])
      else $error("module one not active in pwm mode");
   a_active_mod4: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (state.regs.pwm_mode[3] && sel_out[7:6] != 2'b11) |-> pwm_active_out[3])
      else $error("module four not active in pwm mode");
   // reset leaves every module on timer 2 and out of pwm mode
   a_reset_mode: assert property (@(posedge clk_in)
      !rstn_in |=> state.regs.pwm_mode == 4'h0 && pwm_active_out == 4'h0 && pwm_tick_out == 4'h0)
      else $error("pwm gating not cleared by reset");

   // -----------------------------------------------------------
   // register bus answers
   // -----------------------------------------------------------
   // a write with byte lane 0 masked leaves the selection alone
   a_strobe_mask: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (access && pwrite_in && hit_sel && !pstrb_in[0]) |=> $stable(sel_out))
      else $error("masked write changed the selection");
   // unmapped addresses answer with an error, read zero and change nothing
   a_err_unmapped: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (access && !(hit_sel || hit_mode)) |-> pslverr_out && prdata_out == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (access && (hit_sel || hit_mode)) |-> !pslverr_out)
      else $error("mapped access answered with an error");
   a_unmapped_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (access && pwrite_in && !(hit_sel || hit_mode)) |=> $stable(sel_out) && $stable(state.regs.pwm_mode))
      else $error("unmapped write changed a register");
   // the mode register holds between writes and reads back as stored
   a_mode_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !(access && pwrite_in && hit_mode && pstrb_in[0]) |=> $stable(state.regs.pwm_mode))
      else $error("pwm mode changed without write");
   a_mode_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (access && !pwrite_in && hit_mode) |-> prdata_out == {28'h000_0000, state.regs.pwm_mode})
      else $error("read data differs from pwm mode");
endmodule // pts_top
`default_nettype wire

// ---- include/pts_pkg.sv ----
// package: register map, field layout and types of the pwm timebase selection block
package pts_pkg;
   // -----------------------------------------------------------
   // register map
   // -----------------------------------------------------------
   localparam logic [11:0] PTS_SEL0_OFFSET  = 12'h000;
   localparam logic [11:0] PTS_MODE_OFFSET  = 12'h004;
   localparam logic [7:0]  PTS_SEL0_RESET   = 8'h00;
   localparam logic [3:0]  PTS_MODE_RESET   = 4'h0;
   // field positions, low bit of each 2-bit field
   localparam int PTS_MOD1_LSB = 0;
   localparam int PTS_MOD2_LSB = 2;
   localparam int PTS_MOD3_LSB = 4;
   localparam int PTS_MOD4_LSB = 6;
   localparam int PTS_NUM_MOD  = 4;
   // -----------------------------------------------------------
   // types
   // -----------------------------------------------------------
   typedef enum logic [1:0]
   {
      PTS_TB_TIMER2   = 2'b00,
      PTS_TB_TIMER4   = 2'b01,
      PTS_TB_TIMER6   = 2'b10,
      PTS_TB_RESERVED = 2'b11
   } pts_tb_type;

   typedef struct packed
   {
      logic [7:0] sel;   // four 2-bit timebase fields
      logic [3:0] pwm_mode;
   } pts_regs_type;
endpackage

// ---- src/pts_tb_mux.sv ----
// one pwm module's timebase multiplexer
`timescale 1ns/1ps
`default_nettype none
module pts_tb_mux
   import pts_pkg::*;
(
   // selection
   input  wire logic [1:0] sel_in,
   input  wire logic       pwm_mode_in,
   // timebase period-match pulses
   input  wire logic [2:0] tick_in,
   // selected timebase
   output logic            tick_out,
   output logic            active_out
);
   // route chosen timer only in pwm mode; reserved code drives nothing
   always_comb
   begin
      tick_out   = 1'b0;
      active_out = pwm_mode_in && (sel_in != PTS_TB_RESERVED);
      if (pwm_mode_in)
      begin
         unique case (sel_in)
            PTS_TB_TIMER2:   tick_out = tick_in[0];
            PTS_TB_TIMER4:   tick_out = tick_in[1];
            PTS_TB_TIMER6:   tick_out = tick_in[2];
            PTS_TB_RESERVED: tick_out = 1'b0;
         endcase
      end
   end
endmodule // pts_tb_mux
`default_nettype wire

// ---- bench/pts_testbench.sv ----
// self-checking bench for the pwm timebase selection block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import pts_pkg::*;
;
   // ------------------------------------
   // signals
   // ------------------------------------
   logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic [3:0]  pstrb = 0, tick, act;
   logic [2:0]  tin = 0;
   logic [7:0]  sel;
   logic        pready, perr, rerr;
   logic [7:0]  pat [4] = '{8'h24, 8'h49, 8'h92, 8'haa};
   logic [3:0]  mode [2] = '{4'hf, 4'h5};
   int          failures = 0, total_checks = 0;
   always #2.5 clk = ~clk;
   pts_top uut (.clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(perr), .timer_tick_in(tin), .pwm_tick_out(tick), .pwm_active_out(act), .sel_out(sel));
   // ------------------------------------
   // tasks
   // ------------------------------------
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      psel <= 1; pwr <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rdat = prdata;
      rerr = perr;
      psel <= 0; pen <= 0;
   endtask
   // expected selected tick per module
   function automatic logic [3:0] want(input logic [7:0] s, input logic [3:0] m, input logic [2:0] t);
      logic [1:0] c;
      want = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         c = s[2*i +: 2];
         want[i] = m[i] && c != 2'b11 && t[c];
      end
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------------------------------------
   // tests
   // ------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      rstn <= 1;
      apb(0, 12'h000, 0, 4'h1);
      chk("sel reset", rdat, 0);
      chk("active reset", act, 0);
      chk("ready", pready, 1);
      foreach (mode[k])
      begin
         apb(1, 12'h004, mode[k], 4'h1);
         apb(0, PTS_MODE_OFFSET, 0, 4'h1);
         chk("mode read", rdat, mode[k]);
         foreach (pat[p])
         begin
            apb(1, 12'h000, {24'hffffff, pat[p]}, 4'h1);
            apb(0, 12'h000, 0, 4'h1);
            chk("sel read", rdat, pat[p]);
            chk("sel out", sel, pat[p]);
            chk("sel err", rerr, 0);
            chk("active", act, want(pat[p], mode[k], 3'h7));
            for (int t = 0; t < 3; t++)
            begin
               @(posedge clk) tin <= 3'h1 << t;
               @(negedge clk) chk("tick", tick, want(pat[p], mode[k], 3'h1 << t));
            end
         end
      end
      apb(1, 12'h008, 32'h0000_0012, 4'h1);
      chk("unmapped write err", rerr, 1);
      apb(1, 12'h000, 8'h12, 4'h0);
      @(negedge clk) chk("masked write", sel, pat[3]);
      apb(0, 12'h008, 0, 4'h1);
      chk("unmapped err", rerr, 1);
      chk("unmapped data", rdat, 0);
      @(posedge clk) rstn <= 0;
      @(posedge clk) rstn <= 1;
      @(negedge clk) chk("sel after reset", sel, 0);
      chk("active after reset", act, 0);
      apb(0, PTS_MODE_OFFSET, 0, 4'h1);
      chk("mode after reset", rdat, 0);
      final_report;
   end
   // watchdog
   initial
   begin
      repeat (3000) @(posedge clk);
      failures++;
      final_report;
   end
endmodule // testbench
`default_nettype wire
